// [hdl/tcct_defines.svh]
`ifndef TCCT_DEFINES_SVH
`define TCCT_DEFINES_SVH

// ----------------------------------------------------------------------
// Window placement on the CPU memory bus (word addresses)
// ----------------------------------------------------------------------
`define TCCT_ADDR_W 22
`define TCCT_BASE_WORD 22'h000C00
`define TCCT_WIN_WORDS 64
`define TCCT_WIN_TAG 16'h0030

// ----------------------------------------------------------------------
// Per-timer word offsets inside a stride of eight words
// ----------------------------------------------------------------------
`define TCCT_TMR_STRIDE 8
`define TCCT_OFF_CNT_LO 3'h0
`define TCCT_OFF_CNT_HI 3'h1
`define TCCT_OFF_PRD_LO 3'h2
`define TCCT_OFF_PRD_HI 3'h3
`define TCCT_OFF_PSC 3'h4

// ----------------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------------
`define TCCT_NUM_TMR 3
`define TCCT_CNT_W 32
`define TCCT_PSC_W 16
`define TCCT_CNT_RST 32'hFFFFFFFF
`define TCCT_PRD_RST 32'hFFFFFFFF
`define TCCT_PSC_RST 16'h0000

`endif

// [hdl/tcct_pkg.sv]
`include "tcct_defines.svh"

package tcct_pkg;

   // ----------------------------------------------------------------------
   // Bus carrier and state types
   // ----------------------------------------------------------------------
   typedef logic [`TCCT_CNT_W-1:0] tcct_word_t;
   typedef logic [`TCCT_PSC_W-1:0] tcct_half_t;

   typedef struct packed {
      logic req;
      logic we;
      logic wide;
      logic [`TCCT_ADDR_W-1:0] addr;
      tcct_word_t wdata;
   } tcct_bus_req_s;

   typedef struct packed {
      logic ack;
      tcct_word_t rdata;
      logic [`TCCT_NUM_TMR-1:0][`TCCT_CNT_W-1:0] period;
      logic [`TCCT_NUM_TMR-1:0][`TCCT_PSC_W-1:0] psc;
   } tcct_top_s;

   typedef struct packed {
      tcct_half_t cnt;
   } tcct_psc_s;

   typedef struct packed {
      tcct_word_t count;
      logic irq;
   } tcct_cnt_s;

endpackage

// [hdl/tcct_prescaler.sv]
`timescale 1ns/1ps
`include "tcct_defines.svh"

module tcct_prescaler
   import tcct_pkg::*;
#(
   parameter int PSC_W = `TCCT_PSC_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Setting
   input wire logic [PSC_W-1:0] i_div,
   input wire logic i_restart,
   // Tick
   output logic o_tick
);

   tcct_psc_s q;
   tcct_psc_s d;
   logic [PSC_W-1:0] reload;

   // Setting of 0 or 1 both give a tick on every clock
   assign reload = (i_div == '0) ? '0 : i_div - 1'b1;
   assign o_tick = (q.cnt == '0);

   always_comb begin
      d = q;
      if (i_restart || q.cnt == '0) begin
         d.cnt = reload;
      end else begin
         d.cnt = q.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   tick_spacing_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      (o_tick && i_div == 16'h0003 && !i_restart) ##1 (i_div == 16'h0003 && !i_restart) [*2]
      |-> !o_tick ##1 o_tick)
      else $error("prescaler tick not every third clock");

   tick_reload_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      o_tick && !i_restart |=> q.cnt == $past(reload))
      else $error("prescaler did not reload at zero");

endmodule // tcct_prescaler

// [hdl/tcct_downcount.sv]
`timescale 1ns/1ps
`include "tcct_defines.svh"

module tcct_downcount
   import tcct_pkg::*;
(
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Controls
   input wire logic i_tick,
   input wire tcct_word_t i_period,
   input wire logic i_wr_lo,
   input wire logic i_wr_hi,
   input wire tcct_word_t i_wdata,
   // State
   output tcct_word_t o_count,
   output logic o_irq
);

   tcct_cnt_s q;
   tcct_cnt_s d;

   assign o_count = q.count;
   assign o_irq = q.irq;

   always_comb begin
      d = q;
      d.irq = 1'b0;
      if (i_wr_lo || i_wr_hi) begin
         // Software write beats a tick in the same cycle
         if (i_wr_lo) begin
            d.count[15:0] = i_wdata[15:0];
         end
         if (i_wr_hi) begin
            d.count[31:16] = i_wdata[31:16];
         end
      end else if (i_tick) begin
         if (q.count == '0) begin
            d.count = i_period;
            d.irq = 1'b1;
         end else begin
            d.count = q.count - 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q.count <= `TCCT_CNT_RST;
         q.irq <= 1'b0;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   count_decrement_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_tick && q.count != '0 && !i_wr_lo && !i_wr_hi |=> q.count == $past(q.count) - 1)
      else $error("counter did not decrement on tick");

   count_reload_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_tick && q.count == '0 && !i_wr_lo && !i_wr_hi |=> q.count == $past(i_period) && q.irq)
      else $error("counter did not reload with interrupt at zero");

   irq_cause_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      q.irq |-> $past(i_tick && q.count == '0 && !i_wr_lo && !i_wr_hi))
      else $error("interrupt pulse without a zero reload");

   count_hold_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !i_tick && !i_wr_lo && !i_wr_hi |=> $stable(q.count) && !q.irq)
      else $error("counter moved without tick or write");

endmodule // tcct_downcount

// [hdl/tcct_timers.sv]
`timescale 1ns/1ps
`include "tcct_defines.svh"

// What this block does
// - Three timers, 32-bit counter and period each
// - Counter decrements once per prescale-setting clocks (every clock for setting 0)
// - Interrupt on the tick that finds the counter at zero
// - Zero reloads counter from period automatically
// - Timer two drives CPU interrupt line fourteen
// - Timer one drives CPU interrupt line thirteen
// - Timer zero goes to interrupt expander
// - 64-word window at 0x0C00, no unlock
// - Sixteen and thirty-two bit accesses accepted
// - Slave sits directly on CPU memory bus

module tcct_timers
   import tcct_pkg::*;
#(
   parameter int NUM_TMR = `TCCT_NUM_TMR,
   parameter int PSC_W = `TCCT_PSC_W
) (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // CPU memory bus
   input wire tcct_bus_req_s i_bus,
   output logic o_ack,
   output tcct_word_t o_rdata,
   // Interrupt requests
   output logic o_irq_peripheral_interrupt_expander,
   output logic o_irq_cpu_interrupt_line_thirteen,
   output logic o_irq_cpu_interrupt_line_fourteen
);

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   tcct_top_s q;
   tcct_top_s d;
   logic in_win;
   logic [5:0] off;
   logic [2:0] sel_tmr;
   logic [2:0] sel_reg;
   logic lo_en;
   logic hi_en;
   tcct_word_t wdat;
   logic [NUM_TMR-1:0] tmr_hit;
   logic [NUM_TMR-1:0] cnt_wr_lo;
   logic [NUM_TMR-1:0] cnt_wr_hi;
   logic [NUM_TMR-1:0] psc_restart;
   logic [NUM_TMR-1:0] tick;
   logic [NUM_TMR-1:0] irq;
   logic [NUM_TMR-1:0][`TCCT_CNT_W-1:0] count;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Replace selected halves of a 32-bit value
   function automatic tcct_word_t merge16(input tcct_word_t old_v, input tcct_word_t new_v,
                                          input logic lo, input logic hi);
      tcct_word_t r;
      r = old_v;
      if (lo) begin
         r[15:0] = new_v[15:0];
      end
      if (hi) begin
         r[31:16] = new_v[31:16];
      end
      return r;
   endfunction

   // One 16-bit word of the window; holes read as zero
   function automatic tcct_half_t read_half(
         input logic [5:0] o,
         input logic [NUM_TMR-1:0][`TCCT_CNT_W-1:0] cnt_v,
         input logic [NUM_TMR-1:0][`TCCT_CNT_W-1:0] prd_v,
         input logic [NUM_TMR-1:0][PSC_W-1:0] psc_v);
      tcct_half_t r;
      r = 16'h0000;
      for (int t = 0; t < NUM_TMR; t++) begin
         if (o[5:3] == 3'(t)) begin
            unique case (o[2:0])
               `TCCT_OFF_CNT_LO: r = cnt_v[t][15:0];
               `TCCT_OFF_CNT_HI: r = cnt_v[t][31:16];
               `TCCT_OFF_PRD_LO: r = prd_v[t][15:0];
               `TCCT_OFF_PRD_HI: r = prd_v[t][31:16];
               `TCCT_OFF_PSC: r = psc_v[t];
               default: r = 16'h0000;
            endcase
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // No unlock gating: every register write inside the window lands
   assign in_win = (i_bus.addr[`TCCT_ADDR_W-1:6] == `TCCT_WIN_TAG);
   assign off = i_bus.addr[5:0];
   assign sel_tmr = off[5:3];
   assign sel_reg = off[2:0];

   // A wide access uses the even word; its odd partner takes the top half
   assign lo_en = i_bus.wide | ~off[0];
   assign hi_en = i_bus.wide | off[0];
   assign wdat = i_bus.wide ? i_bus.wdata : {i_bus.wdata[15:0], i_bus.wdata[15:0]};

   always_comb begin
      for (int t = 0; t < NUM_TMR; t++) begin
         tmr_hit[t] = i_bus.req && i_bus.we && in_win && sel_tmr == 3'(t);
         cnt_wr_lo[t] = tmr_hit[t] && sel_reg[2:1] == 2'h0 && lo_en;
         cnt_wr_hi[t] = tmr_hit[t] && sel_reg[2:1] == 2'h0 && hi_en;
         // Bit0 ignored on a wide access, as for the count and period words
         psc_restart[t] = tmr_hit[t] && sel_reg[2:1] == 2'h2 && lo_en;
      end
   end

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   always_comb begin
      d = q;
      d.ack = i_bus.req && in_win;
      if (i_bus.req && in_win && !i_bus.we) begin
         if (i_bus.wide) begin
            d.rdata = {read_half({off[5:1], 1'b1}, count, q.period, q.psc),
                       read_half({off[5:1], 1'b0}, count, q.period, q.psc)};
         end else begin
            d.rdata = {16'h0000, read_half(off, count, q.period, q.psc)};
         end
      end
      for (int t = 0; t < NUM_TMR; t++) begin
         if (tmr_hit[t] && sel_reg[2:1] == 2'h1) begin
            d.period[t] = merge16(q.period[t], wdat, lo_en, hi_en);
         end
         if (psc_restart[t]) begin
            d.psc[t] = wdat[15:0];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         q.ack <= 1'b0;
         q.rdata <= '0;
         q.period <= {NUM_TMR{`TCCT_PRD_RST}};
         q.psc <= {NUM_TMR{`TCCT_PSC_RST}};
      end else begin
         q <= d;
      end
   end

   assign o_ack = q.ack;
   assign o_rdata = q.rdata;

   // ----------------------------------------------------------------------
   // Timers
   // ----------------------------------------------------------------------
   for (genvar g = 0; g < NUM_TMR; g++) begin : g_tmr
      tcct_prescaler #(
         .PSC_W(PSC_W)
      ) u_psc (
         .i_clk(i_clk),
         .i_rstn(i_rstn),
         .i_div(q.psc[g]),
         .i_restart(psc_restart[g]),
         .o_tick(tick[g])
      );

      tcct_downcount u_cnt (
         .i_clk(i_clk),
         .i_rstn(i_rstn),
         .i_tick(tick[g]),
         .i_period(q.period[g]),
         .i_wr_lo(cnt_wr_lo[g]),
         .i_wr_hi(cnt_wr_hi[g]),
         .i_wdata(wdat),
         .o_count(count[g]),
         .o_irq(irq[g])
      );
   end

   // ----------------------------------------------------------------------
   // Interrupt routing
   // ----------------------------------------------------------------------
   // Each line is the counter's own pulse flop, no extra latency
   assign o_irq_peripheral_interrupt_expander = irq[0];
   assign o_irq_cpu_interrupt_line_thirteen = irq[1];
   assign o_irq_cpu_interrupt_line_fourteen = irq[2];

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   bus_ack_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && in_win |=> o_ack)
      else $error("window access not acknowledged next clock");

   bus_ignore_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !(i_bus.req && in_win) |=> !o_ack)
      else $error("acknowledge outside the window");

   period_wide_wr_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && i_bus.we && i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h000002
      |=> q.period[0] == $past(i_bus.wdata))
      else $error("wide period write lost");

   period_half_wr_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && i_bus.we && !i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h00000B
      |=> q.period[1][31:16] == $past(i_bus.wdata[15:0])
          && q.period[1][15:0] == $past(q.period[1][15:0]))
      else $error("upper half period write wrong");

   period_wide_rd_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && !i_bus.we && i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h000012
      |=> o_rdata == $past(q.period[2]))
      else $error("wide period read wrong");

   psc_half_rd_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && !i_bus.we && !i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h000004
      |=> o_rdata == {16'h0000, $past(q.psc[0])})
      else $error("prescale read wrong");

   pie_route_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      o_irq_peripheral_interrupt_expander |-> count[0] == q.period[0] || $past(i_bus.we))
      else $error("expander pulse without timer zero reload");

   line13_route_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      o_irq_cpu_interrupt_line_thirteen |-> count[1] == q.period[1] || $past(i_bus.we))
      else $error("line thirteen pulse without timer one reload");

   line14_route_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      o_irq_cpu_interrupt_line_fourteen |-> count[2] == q.period[2] || $past(i_bus.we))
      else $error("line fourteen pulse without timer two reload");

   irq_pulse_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      $rose(o_irq_cpu_interrupt_line_fourteen) && q.psc[2] > 16'h0001 && !psc_restart[2]
      |=> !o_irq_cpu_interrupt_line_fourteen)
      else $error("interrupt pulse longer than one clock");

   exp_pulse_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      $rose(o_irq_peripheral_interrupt_expander) && q.psc[0] > 16'h0001 && !psc_restart[0]
      |=> !o_irq_peripheral_interrupt_expander)
      else $error("expander pulse longer than one clock");

   hole_read_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && in_win && !i_bus.we && !i_bus.wide && off[2:0] > 3'h4
      |=> o_rdata == 32'h00000000)
      else $error("hole in the window did not read zero");

   rdata_hold_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      !(i_bus.req && in_win && !i_bus.we) |=> $stable(o_rdata))
      else $error("read data changed without a read");

   period_lo_wr_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && i_bus.we && !i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h00000A
      |=> q.period[1][15:0] == $past(i_bus.wdata[15:0])
          && q.period[1][31:16] == $past(q.period[1][31:16]))
      else $error("lower half period write wrong");

   psc_half_wr_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && i_bus.we && !i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h000004
      |=> q.psc[0] == $past(i_bus.wdata[15:0]))
      else $error("prescale write lost");

   psc_wide_odd_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && i_bus.we && i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h00000D
      |=> q.psc[1] == $past(i_bus.wdata[15:0]))
      else $error("wide prescale write at odd word lost");

   cnt_half_wr_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && i_bus.we && !i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h000008
      |=> count[1][15:0] == $past(i_bus.wdata[15:0]))
      else $error("lower half count write lost");

   cnt_half_rd_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && !i_bus.we && !i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h000008
      |=> o_rdata == {16'h0000, $past(count[1][15:0])})
      else $error("lower half count read wrong");

   cnt_wide_rd_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && !i_bus.we && i_bus.wide && i_bus.addr == `TCCT_BASE_WORD + 22'h000009
      |=> o_rdata == $past(count[1]))
      else $error("wide count read wrong");

   outside_write_a: assert property (
      @(posedge i_clk) disable iff (!i_rstn)
      i_bus.req && i_bus.we && !in_win |=> $stable(q.period) && $stable(q.psc))
      else $error("write outside the window changed a setting");

endmodule // tcct_timers

// [sim/tcct_irq_sink.sv]
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// Interrupt receiver: counts pulses and spacing per line
// ----------------------------------------------------------------------
module tcct_irq_sink (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_rstn,
   // Interrupt lines: expander, line thirteen, line fourteen
   input wire logic [2:0] i_irq,
   // Observations
   output logic [2:0][7:0] o_cnt,
   output logic [2:0][15:0] o_gap,
   output logic o_wide
);
   logic [15:0] cyc_q;
   logic [2:0][15:0] last_q;
   logic [2:0] prev_q;

   // Level sampled sink: a request held two clocks counts twice and sets o_wide
   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         cyc_q <= '0;
         last_q <= '0;
         prev_q <= '0;
         o_cnt <= '0;
         o_gap <= '0;
         o_wide <= 1'b0;
      end else begin
         cyc_q <= cyc_q + 16'h0001;
         prev_q <= i_irq;
         for (int t = 0; t < 3; t++) begin
            if (i_irq[t]) begin
               o_cnt[t] <= o_cnt[t] + 8'h01;
               o_gap[t] <= cyc_q - last_q[t];
               last_q[t] <= cyc_q;
               if (prev_q[t]) begin
                  o_wide <= 1'b1;
               end
            end
         end
      end
   end
endmodule // tcct_irq_sink

// [sim/tcct_timers_test.sv]
`timescale 1ns/1ps

module tcct_timers_test import tcct_pkg::*;;
   logic i_clk = 1'b0;
   logic i_rstn = 1'b0;
   tcct_bus_req_s bus = '0;
   logic o_ack;
   tcct_word_t o_rdata;
   logic [2:0] irq;
   logic [2:0][7:0] cnt;
   logic [2:0][15:0] gap;
   logic wide;
   int num_errors = 0;
   int comparisons = 0;

   always #50 i_clk = ~i_clk;

   tcct_timers tcct_timers_inst (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_bus(bus),
      .o_ack(o_ack),
      .o_rdata(o_rdata),
      .o_irq_peripheral_interrupt_expander(irq[0]),
      .o_irq_cpu_interrupt_line_thirteen(irq[1]),
      .o_irq_cpu_interrupt_line_fourteen(irq[2])
   );

   tcct_irq_sink tcct_irq_sink_inst (
      .i_clk(i_clk),
      .i_rstn(i_rstn),
      .i_irq(irq),
      .o_cnt(cnt),
      .o_gap(gap),
      .o_wide(wide)
   );

   // ----------------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------------
   task check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Ack is registered on the taking edge itself and checked just after it, so no polling needed
   task access(input logic we, input logic wd, input logic [21:0] a,
               input tcct_word_t d, input logic ack_exp);
      @(posedge i_clk);
      bus <= '{req: 1'b1, we: we, wide: wd, addr: a, wdata: d};
      @(posedge i_clk);
      bus.req <= 1'b0;
      #1;
      check(o_ack, ack_exp);
   endtask

   task rd(input logic wd, input logic [21:0] a, input tcct_word_t exp);
      access(1'b0, wd, a, '0, 1'b1);
      check(o_rdata, exp);
   endtask

   task wait_pulses(input int t, input int n);
      logic [7:0] start;
      int k;
      start = cnt[t];
      for (k = 0; k < 400 && 8'(cnt[t] - start) < n; k++) begin
         @(posedge i_clk);
      end
      if (8'(cnt[t] - start) < n) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, cnt[t], start);
      end
      #1;
   endtask

   task stop_test();
      $display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task test_reset();
      rd(1'b1, 22'h000C02, 32'hFFFFFFFF);
      rd(1'b0, 22'h000C13, 32'h0000FFFF);
      rd(1'b1, 22'h000C12, 32'hFFFFFFFF);
      rd(1'b0, 22'h000C0C, 32'h00000000);
      rd(1'b0, 22'h000C04, 32'h00000000);
      check(32'(cnt), 32'h00000000);
      $display("test_reset done");
   endtask

   task test_access();
      access(1'b1, 1'b0, 22'h000C0A, 32'h00001234, 1'b1);
      access(1'b1, 1'b0, 22'h000C0B, 32'h0000ABCD, 1'b1);
      rd(1'b1, 22'h000C0A, 32'hABCD1234);
      rd(1'b1, 22'h000C0B, 32'hABCD1234);
      rd(1'b0, 22'h000C0B, 32'h0000ABCD);
      rd(1'b0, 22'h000C05, 32'h00000000);
      // Alias of period1 outside the window must be ignored
      access(1'b1, 1'b1, 22'h001C0A, 32'h55555555, 1'b0);
      access(1'b0, 1'b1, 22'h000C40, '0, 1'b0);
      access(1'b0, 1'b1, 22'h000BFF, '0, 1'b0);
      rd(1'b1, 22'h000C0A, 32'hABCD1234);
      $display("test_access done");
   endtask

   task test_irq();
      tcct_word_t prd [3];
      tcct_word_t psc [3];
      prd = '{32'h00000002, 32'h00000004, 32'h00000001};
      psc = '{32'h00000003, 32'h00000001, 32'h00000002};
      for (int t = 0; t < 3; t++) begin
         access(1'b1, 1'b1, 22'(22'h000C02 + 8 * t), prd[t], 1'b1);
         access(1'b1, 1'b0, 22'(22'h000C04 + 8 * t), psc[t], 1'b1);
         access(1'b1, 1'b1, 22'(22'h000C00 + 8 * t), '0, 1'b1);
      end
      rd(1'b0, 22'h000C04, 32'h00000003);
      for (int t = 0; t < 3; t++) begin
         wait_pulses(t, 3);
         check(gap[t], psc[t] * (prd[t] + 1));
      end
      // Setting zero divides like setting one
      access(1'b1, 1'b0, 22'h000C0C, '0, 1'b1);
      wait_pulses(1, 3);
      check(gap[1], 32'h00000005);
      check(wide, 1'b0);
      $display("test_irq done");
   endtask

   // Slowest prescale freezes timer one so its count reads back exactly
   task test_count();
      access(1'b1, 1'b1, 22'h000C0D, 32'h0000FFFF, 1'b1);
      rd(1'b0, 22'h000C0C, 32'h0000FFFF);
      access(1'b1, 1'b0, 22'h000C08, 32'h00001357, 1'b1);
      access(1'b1, 1'b0, 22'h000C09, 32'h00002468, 1'b1);
      rd(1'b1, 22'h000C09, 32'h24681357);
      rd(1'b0, 22'h000C08, 32'h00001357);
      $display("test_count done");
   endtask

   // ----------------------------------------------------------------------
   // Main sequence and hang guard
   // ----------------------------------------------------------------------
   initial begin
      repeat (6) @(posedge i_clk);
      i_rstn <= 1'b1;
      test_reset();
      test_access();
      test_irq();
      test_count();
      stop_test();
   end

   initial begin
      repeat (20000) @(posedge i_clk);
      num_errors++;
      stop_test();
   end
endmodule // tcct_timers_test
